/* File: hw/tdccfg_regs.sv */
// Configuration register bank with fire output stage and interrupt logic
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module tdccfg_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire tdccfg_pkg::tdccfg_bus_type bus,
  output logic [23:0] rdata,
  input wire tdccfg_pkg::tdccfg_event_type events,
  input wire logic fire_seq_level,
  input wire logic [3:0] fire_pulse_index,
  input wire logic [31:0] alu_result,
  output tdccfg_pkg::tdccfg_measure_type measure_cfg,
  output tdccfg_pkg::tdccfg_fire_type fire_cfg,
  output logic [31:0] result_out,
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic range_two_mode,
  output logic irq
);
  import tdccfg_pkg::*;

  logic [23:0] setup;
  logic [23:0] delay_a;
  logic [23:0] delay_b;
  logic [23:0] delay_c;
  logic [23:0] pulse;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] raised;
  logic [2:0] enabled_src;
  logic [2:0] next_status;
  logic shaped;
  logic [3:0] operand_a;
  logic [3:0] operand_b;
  logic ops_ok;

  function automatic tdccfg_operand_kind_type operand_kind(
    input logic [3:0] code);
    tdccfg_operand_kind_type kind;
    kind = op_invalid;
    case (code)
      OP_START: kind = op_start;
      4'h1, 4'h2, 4'h3, 4'h4: kind = op_stop_one;
      OP_NO_ACTION: kind = op_none;
      OP_CAL_A, OP_CAL_B: kind = op_calib;
      4'h9, 4'hA, 4'hB, 4'hC: kind = op_stop_two;
      default: kind = op_invalid;
    endcase
    return kind;
  endfunction

  // Out-of-range hit codes would arm more stop slots than exist
  function automatic logic [2:0] clamp_hits(input logic [2:0] code);
    return (code > MAX_HITS) ? MAX_HITS : code;
  endfunction

  function automatic logic [15:0] timeout_cycles(input logic [1:0] sel);
    logic [15:0] us;
    case (sel)
      2'h0: us = 16'(TIMEOUT_US_0);
      2'h1: us = 16'(TIMEOUT_US_1);
      2'h2: us = 16'(TIMEOUT_US_2);
      default: us = 16'(TIMEOUT_US_3);
    endcase
    return 16'(us * HS_CLOCK_MHZ);
  endfunction

  // Every write to setup, delay_a, delay_b, delay_c or pulse lands the whole 24-bit word at once
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      setup <= RESET_SETUP;
      delay_a <= RESET_DELAY_A;
      delay_b <= RESET_DELAY_B;
      delay_c <= RESET_DELAY_C;
      pulse <= RESET_PULSE;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        ADDR_SETUP: setup <= bus.wdata;
        ADDR_DELAY_A: delay_a <= bus.wdata;
        ADDR_DELAY_B: delay_b <= bus.wdata;
        ADDR_DELAY_C: delay_c <= bus.wdata;
        ADDR_PULSE: pulse <= bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      range_two_mode <= 1'b0;
    else if (bus.wr && bus.addr == ADDR_MODE)
      range_two_mode <= bus.wdata[0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask <= IRQ_ZERO;
    else if (bus.wr && bus.addr == ADDR_IRQ_MASK)
      irq_mask <= bus.wdata[2:0];
  end

  assign enabled_src = {delay_a[IRQ_TIMEOUT_BIT], delay_a[IRQ_HITS_BIT],
    delay_a[IRQ_ALU_BIT]};
  assign raised = {events.timeout, events.end_of_hits, events.alu_done}
    & enabled_src;

  // A new event in the clearing read still wins
  always_comb
  begin
    next_status = irq_status;
    if (bus.rd && bus.addr == ADDR_IRQ_STATUS)
      next_status = IRQ_ZERO;
    next_status = next_status | raised;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_status <= IRQ_ZERO;
    else
      irq_status <= next_status;
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= REG_ZERO;
    else if (bus.rd)
    begin
      case (bus.addr)
        ADDR_SETUP: rdata <= setup;
        ADDR_DELAY_A: rdata <= delay_a;
        ADDR_DELAY_B: rdata <= delay_b;
        ADDR_DELAY_C: rdata <= delay_c;
        ADDR_PULSE: rdata <= pulse;
        ADDR_IRQ_STATUS: rdata <= {21'h000000, irq_status};
        ADDR_IRQ_MASK: rdata <= {21'h000000, irq_mask};
        ADDR_MODE: rdata <= {23'h000000, range_two_mode};
        default: rdata <= REG_ZERO;
      endcase
    end
    else
      rdata <= REG_ZERO;
  end

  assign operand_a = setup[OPERAND_A_LSB +: 4];
  assign operand_b = setup[OPERAND_B_LSB +: 4];

  // Range 2 accepts only stop code 1 for operand a and stop codes 2 to 4 for b
  always_comb
  begin
    if (range_two_mode)
      ops_ok = (operand_a == 4'h1) && (operand_b >= 4'h2)
        && (operand_b <= 4'h4);
    else
      ops_ok = (operand_kind(operand_a) != op_invalid)
        && (operand_kind(operand_b) != op_invalid);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      measure_cfg <= '0;
    else
    begin
      measure_cfg.expected_hits_ch_one <=
        clamp_hits(setup[HITS_ONE_LSB +: 3]);
      measure_cfg.expected_hits_ch_two <=
        clamp_hits(setup[HITS_TWO_LSB +: 3]);
      measure_cfg.fast_init <= setup[FAST_INIT_BIT];
      measure_cfg.alu_operand_a <= operand_a;
      measure_cfg.alu_operand_b <= operand_b;
      measure_cfg.operand_valid <= ops_ok;
      measure_cfg.stop_window_delay_a <= delay_a[DELAY_LSB +: 19];
      measure_cfg.stop_window_delay_b <= delay_b[DELAY_LSB +: 19];
      measure_cfg.stop_window_delay_c <= delay_c[DELAY_LSB +: 19];
      measure_cfg.dual_edge_ch_one <= delay_a[EDGE_ONE_BIT];
      measure_cfg.dual_edge_ch_two <= delay_a[EDGE_TWO_BIT];
      measure_cfg.range_two_timeout_select <= delay_b[TIMEOUT_SEL_LSB +: 2];
      measure_cfg.timeout_hs_cycles <=
        timeout_cycles(delay_b[TIMEOUT_SEL_LSB +: 2]);
      measure_cfg.timeout_all_ones_enable <= delay_b[ALL_ONES_BIT];
      measure_cfg.start_jitter_enable <= pulse[START_JITTER_BIT];
      measure_cfg.phase_jitter_disable <= pulse[JITTER_OFF_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      fire_cfg <= '0;
    else
    begin
      fire_cfg.phase <= pulse[PHASE_LSB +: 16];
      fire_cfg.repeat_count <= pulse[REPEAT_LSB +: 3];
      fire_cfg.pulse_output_config <= pulse[DISABLE_A_BIT +: 3];
    end
  end

  // Timeout substitution only when the all-ones option is armed
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      result_out <= 32'h00000000;
    else if (events.timeout && delay_b[ALL_ONES_BIT])
      result_out <= 32'hFFFFFFFF;
    else if (events.alu_done)
      result_out <= alu_result;
  end

  assign shaped = fire_seq_level ^ pulse[PHASE_LSB + fire_pulse_index];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pulse_out_a <= 1'b0;
      pulse_out_b <= 1'b0;
    end
    else
    begin
      pulse_out_a <= shaped & ~pulse[DISABLE_A_BIT];
      pulse_out_b <= (shaped ^ pulse[NEGATE_B_BIT])
        & ~pulse[DISABLE_B_BIT];
    end
  end
endmodule

/* File: hw/tdccfg_pkg.sv */
// Constants, field layouts and types for the converter configuration bank
// Operation
// - Channel one hits 0 disables, 1-4 hits
// - Channel two hits 0 disables, 1-4 hits
// - Fast init bit turns fast init mode on
// - Operand selectors encode start, stops, calibration
// - Delay is 14.5 unsigned fixed point, bits 0-18
// - Registers 2-4 set hit 1-3 windows
// - Edge bit picks single or both edges
// - Interrupt is OR of enabled sources
// - Timeout select gives 64 to 4096 microseconds
// - Error-value bit forces all-ones result on timeout
// - Phase bits invert matching fire pulses
// - Repeat field repeats sequence 0-7 times
// - Start jitter bit enables start noise unit
// - Output config negates/disables pulse outputs
// - Reset loads documented default values
package tdccfg_pkg;
  localparam int unsigned REG_WIDTH = 24;
  localparam logic [3:0] ADDR_SETUP = 4'h1;
  localparam logic [3:0] ADDR_DELAY_A = 4'h2;
  localparam logic [3:0] ADDR_DELAY_B = 4'h3;
  localparam logic [3:0] ADDR_DELAY_C = 4'h4;
  localparam logic [3:0] ADDR_PULSE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_MODE = 4'h8;
  // Power-on defaults
  localparam logic [23:0] RESET_SETUP = 24'h554000;
  localparam logic [23:0] RESET_DELAY_A = 24'h200000;
  localparam logic [23:0] RESET_DELAY_B = 24'h180000;
  localparam logic [23:0] RESET_DELAY_C = 24'h200000;
  localparam logic [23:0] RESET_PULSE = 24'h000000;
  // Field positions
  localparam int unsigned HITS_ONE_LSB = 8;
  localparam int unsigned HITS_TWO_LSB = 11;
  localparam int unsigned FAST_INIT_BIT = 15;
  localparam int unsigned OPERAND_A_LSB = 16;
  localparam int unsigned OPERAND_B_LSB = 20;
  localparam int unsigned DELAY_LSB = 0;
  localparam int unsigned EDGE_ONE_BIT = 19;
  localparam int unsigned EDGE_TWO_BIT = 20;
  localparam int unsigned IRQ_ALU_BIT = 21;
  localparam int unsigned IRQ_HITS_BIT = 22;
  localparam int unsigned IRQ_TIMEOUT_BIT = 23;
  localparam int unsigned TIMEOUT_SEL_LSB = 19;
  localparam int unsigned ALL_ONES_BIT = 21;
  localparam int unsigned PHASE_LSB = 0;
  localparam int unsigned REPEAT_LSB = 16;
  localparam int unsigned JITTER_OFF_BIT = 19;
  localparam int unsigned START_JITTER_BIT = 20;
  localparam int unsigned DISABLE_A_BIT = 21;
  localparam int unsigned DISABLE_B_BIT = 22;
  localparam int unsigned NEGATE_B_BIT = 23;
  localparam logic [2:0] MAX_HITS = 3'h4;
  // Timeouts in microseconds at a 4 MHz high speed clock
  localparam int unsigned TIMEOUT_US_0 = 64;
  localparam int unsigned TIMEOUT_US_1 = 256;
  localparam int unsigned TIMEOUT_US_2 = 1024;
  localparam int unsigned TIMEOUT_US_3 = 4096;
  localparam int unsigned HS_CLOCK_MHZ = 4;
  // Operand codes
  localparam logic [3:0] OP_START = 4'h0;
  localparam logic [3:0] OP_NO_ACTION = 4'h5;
  localparam logic [3:0] OP_CAL_A = 4'h6;
  localparam logic [3:0] OP_CAL_B = 4'h7;
  localparam logic [2:0] IRQ_SRC_TIMEOUT = 3'h4;
  localparam logic [2:0] IRQ_SRC_HITS = 3'h2;
  localparam logic [2:0] IRQ_SRC_ALU = 3'h1;
  localparam logic [2:0] IRQ_ZERO = 3'h0;
  localparam logic [23:0] REG_ZERO = 24'h000000;

  typedef enum {op_start, op_stop_one, op_stop_two, op_calib, op_none,
    op_invalid} tdccfg_operand_kind_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } tdccfg_bus_type;

  typedef struct packed {
    logic [2:0] expected_hits_ch_one;
    logic [2:0] expected_hits_ch_two;
    logic fast_init;
    logic [3:0] alu_operand_a;
    logic [3:0] alu_operand_b;
    logic operand_valid;
    logic [18:0] stop_window_delay_a;
    logic [18:0] stop_window_delay_b;
    logic [18:0] stop_window_delay_c;
    logic dual_edge_ch_one;
    logic dual_edge_ch_two;
    logic [1:0] range_two_timeout_select;
    logic [15:0] timeout_hs_cycles;
    logic timeout_all_ones_enable;
    logic start_jitter_enable;
    logic phase_jitter_disable;
  } tdccfg_measure_type;

  typedef struct packed {
    logic [15:0] phase;
    logic [2:0] repeat_count;
    logic [2:0] pulse_output_config;
  } tdccfg_fire_type;

  typedef struct packed {
    logic timeout;
    logic end_of_hits;
    logic alu_done;
  } tdccfg_event_type;
endpackage

/* File: verification/tdccfg_chk.sv */
// Port-level checker for the configuration bank
`timescale 1ns/100ps
module tdccfg_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire tdccfg_pkg::tdccfg_bus_type bus,
  input wire logic [23:0] rdata,
  input wire tdccfg_pkg::tdccfg_event_type events,
  input wire logic fire_seq_level,
  input wire logic [3:0] fire_pulse_index,
  input wire logic [31:0] alu_result,
  input wire tdccfg_pkg::tdccfg_measure_type measure_cfg,
  input wire tdccfg_pkg::tdccfg_fire_type fire_cfg,
  input wire logic [31:0] result_out,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic range_two_mode,
  input wire logic irq
);
  import tdccfg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_forced;
    events.timeout && measure_cfg.timeout_all_ones_enable;
  endsequence
  property p_rdata_idle;
    !$past(bus.rd) |-> rdata == 24'h000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata");
  property p_hits;
    logic [2:0] h;
    (bus.wr && bus.addr == ADDR_SETUP, h = bus.wdata[10:8]) ##1 !bus.wr
      |=> measure_cfg.expected_hits_ch_one == (h > MAX_HITS ? MAX_HITS : h);
  endproperty
  a_hits: assert property (p_hits) else $error("hits");
  property p_delay;
    logic [18:0] v;
    (bus.wr && bus.addr == ADDR_DELAY_A, v = bus.wdata[18:0]) ##1 !bus.wr
      |=> measure_cfg.stop_window_delay_a == v;
  endproperty
  a_delay: assert property (p_delay) else $error("delay");
  property p_irq_fall;
    $fell(irq) |-> $past(bus.rd || bus.wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq");
  property p_forced;
    s_forced |=> result_out == 32'hFFFFFFFF;
  endproperty
  a_forced: assert property (p_forced) else $error("forced");
  property p_alu;
    events.alu_done && !events.timeout |=> result_out == $past(alu_result);
  endproperty
  a_alu: assert property (p_alu) else $error("alu");
  property p_out_a;
    $stable(fire_cfg) |-> pulse_out_a == (!fire_cfg.pulse_output_config[0]
      && $past(fire_seq_level ^ fire_cfg.phase[fire_pulse_index]));
  endproperty
  a_out_a: assert property (p_out_a) else $error("out a");
  property p_out_b;
    $stable(fire_cfg) && !fire_cfg.pulse_output_config[1] |-> pulse_out_b ==
      ($past(fire_seq_level ^ fire_cfg.phase[fire_pulse_index])
      ^ fire_cfg.pulse_output_config[2]);
  endproperty
  a_out_b: assert property (p_out_b) else $error("out b");
  property p_mode;
    bus.wr && bus.addr == ADDR_MODE |=> range_two_mode == $past(bus.wdata[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
endmodule

/* File: verification/tdccfg_engine_model.sv */
// Measurement engine stand-in: fire sequence, events and ALU data
`timescale 1ns/100ps
module tdccfg_engine_model #(
  parameter logic [31:0] ALU_VALUE = 32'h0000ABCD
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire tdccfg_pkg::tdccfg_event_type kick,
  output tdccfg_pkg::tdccfg_event_type events,
  output logic fire_seq_level,
  output logic [3:0] fire_pulse_index,
  output logic [31:0] alu_result
);
  import tdccfg_pkg::*;
  assign alu_result = ALU_VALUE;
  // Walks all sixteen slots so the top phase bit is reached too
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fire_pulse_index <= 4'h0;
      fire_seq_level <= 1'b0;
      events <= '0;
    end
    else
    begin
      fire_pulse_index <= fire_pulse_index + 4'h1;
      fire_seq_level <= ~fire_seq_level;
      events <= kick;
    end
  end
endmodule

/* File: verification/tb_tdccfg_regs.sv */
// Testbench for the converter configuration bank
`timescale 1ns/100ps
module tb_tdccfg_regs;
  import tdccfg_pkg::*;
  localparam logic [23:0] DFLT [5] = '{RESET_SETUP, RESET_DELAY_A,
    RESET_DELAY_B, RESET_DELAY_C, RESET_PULSE};
  localparam int unsigned TMO [4] = '{TIMEOUT_US_0, TIMEOUT_US_1,
    TIMEOUT_US_2, TIMEOUT_US_3};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  tdccfg_bus_type bus = '0;
  tdccfg_event_type events, kick = '0;
  tdccfg_measure_type measure_cfg;
  tdccfg_fire_type fire_cfg;
  logic [23:0] rdata, d;
  logic [3:0] fire_pulse_index;
  logic [31:0] alu_result, result_out;
  logic fire_seq_level, pulse_out_a, pulse_out_b, irq, range_two_mode;
  int n_mismatch = 0;
  int compares = 0;
  always #50 clk = ~clk;
  tdccfg_engine_model eng (.clk(clk), .resetn(resetn), .kick(kick),
    .events(events), .fire_seq_level(fire_seq_level),
    .fire_pulse_index(fire_pulse_index), .alu_result(alu_result));
  tdccfg_regs dut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .events(events), .fire_seq_level(fire_seq_level),
    .fire_pulse_index(fire_pulse_index), .alu_result(alu_result),
    .measure_cfg(measure_cfg), .fire_cfg(fire_cfg), .result_out(result_out),
    .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b),
    .range_two_mode(range_two_mode), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{a, 24'h000000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Event reaches the bank one cycle after the model samples it
  task automatic fire_event(input tdccfg_event_type e);
    @(posedge clk);
    kick <= e;
    @(posedge clk);
    kick <= '0;
    @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    $display("wrong value at %0t: run hung", $time);
    results();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(4'(i + 1));
      chk(d, DFLT[i]);
    end
    rd(4'h0);
    chk(d, 24'h000000);
    $display("test defaults done");
    wr(ADDR_SETUP, 24'h219F00);
    chk(measure_cfg.expected_hits_ch_one, 4);
    chk(measure_cfg.expected_hits_ch_two, 3);
    chk(measure_cfg.fast_init, 1);
    chk({measure_cfg.alu_operand_b, measure_cfg.alu_operand_a}, 8'h21);
    chk(measure_cfg.operand_valid, 1);
    wr(ADDR_DELAY_A, 24'hFFFFFF);
    chk(measure_cfg.stop_window_delay_a, 19'h7FFFF);
    chk({measure_cfg.dual_edge_ch_two, measure_cfg.dual_edge_ch_one}, 3);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_DELAY_B, 24'h200001 | 24'(c << 19));
      chk(measure_cfg.timeout_hs_cycles, TMO[c] * HS_CLOCK_MHZ);
      chk(measure_cfg.stop_window_delay_b, 1);
    end
    wr(ADDR_DELAY_C, 24'h000123);
    chk(measure_cfg.stop_window_delay_c, 19'h00123);
    $display("test measure setup done");
    wr(ADDR_PULSE, 24'h1F8001);
    chk(fire_cfg.phase, 16'h8001);
    chk(fire_cfg.repeat_count, 7);
    chk(measure_cfg.start_jitter_enable, 1);
    repeat (20) @(posedge clk);
    wr(ADDR_PULSE, 24'hA88001);
    chk(fire_cfg.pulse_output_config, 3'h5);
    repeat (20) @(posedge clk);
    #1 chk(pulse_out_a, 0);
    wr(ADDR_PULSE, 24'h488001);
    repeat (20) @(posedge clk);
    #1 chk(pulse_out_b, 0);
    $display("test fire setup done");
    wr(ADDR_IRQ_MASK, 24'h000007);
    fire_event('{1'b1, 1'b0, 1'b0});
    chk(irq, 1);
    chk(result_out, 32'hFFFFFFFF);
    rd(ADDR_IRQ_STATUS);
    chk(d, {21'h0, IRQ_SRC_TIMEOUT});
    chk(irq, 0);
    fire_event('{1'b0, 1'b0, 1'b1});
    chk(result_out, 32'h0000ABCD);
    wr(ADDR_IRQ_MASK, 24'h000000);
    fire_event('{1'b0, 1'b1, 1'b0});
    chk(irq, 0);
    rd(ADDR_IRQ_STATUS);
    chk(d, {21'h0, IRQ_SRC_HITS | IRQ_SRC_ALU});
    wr(ADDR_DELAY_A, 24'h000000);
    fire_event('{1'b1, 1'b1, 1'b1});
    rd(ADDR_IRQ_STATUS);
    chk(d, 24'h000000);
    $display("test interrupts done");
    wr(ADDR_MODE, 24'h000001);
    rd(ADDR_MODE);
    chk(d, 24'h000001);
    chk(range_two_mode, 1);
    wr(ADDR_SETUP, 24'h590000);
    chk(measure_cfg.operand_valid, 0);
    wr(ADDR_SETUP, 24'h210000);
    chk(measure_cfg.operand_valid, 1);
    wr(ADDR_MODE, 24'h000000);
    wr(ADDR_SETUP, 24'h590000);
    chk(measure_cfg.operand_valid, 1);
    wr(ADDR_SETUP, 24'h280000);
    chk(measure_cfg.operand_valid, 0);
    chk(range_two_mode, 0);
    $display("test operand ranges done");
    results();
  end
endmodule
bind tdccfg_regs tdccfg_chk chk_i (.clk(clk), .resetn(resetn), .bus(bus),
  .rdata(rdata), .events(events), .fire_seq_level(fire_seq_level),
  .fire_pulse_index(fire_pulse_index), .alu_result(alu_result),
  .measure_cfg(measure_cfg), .fire_cfg(fire_cfg), .result_out(result_out),
  .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b),
  .range_two_mode(range_two_mode), .irq(irq));
